// [inc/dac_link_pkg.sv]
`default_nettype none
package dac_link_pkg;

    // Upper five bits of the target address; the two lowest address bits are ignored.
    localparam logic [4:0] ADDR_UPPER = 5'h03;
    localparam int ADDR_IGNORED_BITS = 2;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_BIT_IDX = 4'h7;
    localparam logic [15:0] INPUT_REG_RESET = 16'h0000;
    localparam logic [10:0] DAC_REG_RESET = 11'h000;
    localparam int PD_BIT = 15;
    localparam int CODE_MSB = 13;
    localparam int CODE_LSB = 4;
    localparam int CODE_WIDTH = CODE_MSB - CODE_LSB + 1;
    localparam int SYNC_STAGES = 2;

    typedef struct packed {
        logic power_down_control;
        logic spare_hi;
        logic [9:0] converter_code;
        logic [3:0] spare_lo;
    } input_reg_t;

    typedef struct packed {
        logic power_down_control;
        logic [9:0] converter_code;
    } dac_reg_t;

    // Synchronised view of the bus pins and the link-domain edge toggle.
    typedef struct packed {
        logic scl;
        logic sda;
        logic tog;
    } pin_sample_t;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_ADDR     = 3'h1,
        ST_ADDR_ACK = 3'h3,
        ST_WR_BYTE  = 3'h2,
        ST_WR_ACK   = 3'h6,
        ST_RD_BYTE  = 3'h7,
        ST_RD_ACK   = 3'h5,
        ST_IGNORE   = 3'h4
    } link_state_t;

endpackage
`default_nettype wire

// [hw/sync_2ff.sv]
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    // Refused at elaboration: a zero-width synchroniser would carry nothing.
    if (WIDTH < 1) begin : g_width_check
        $error("sync_2ff needs a width of at least one");
    end

    // The first stage is read only by the second stage.
    always_comb begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;

endmodule
`default_nettype wire

// [hw/i2c_dac_code_interface.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_dac_code_interface (
    input wire logic clk,
    input wire logic resetn,
    input wire logic scl_clk,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic power_down_pin,
    output logic [9:0] converter_code,
    output logic power_down,
    output logic link_busy
);

    // Link domain: bits are captured on the bus clock's own rising edge, where the data line is stable.
    logic [7:0] link_shift_r;
    logic [7:0] link_shift_nxt;
    logic link_tog_r;
    logic link_tog_nxt;

    always_comb begin
        link_shift_nxt = {link_shift_r[6:0], sda_i};
        link_tog_nxt = ~link_tog_r;
    end

    always_ff @(posedge scl_clk or negedge resetn) begin
        if (!resetn) begin
            link_shift_r <= 8'h00;
            link_tog_r <= 1'b0;
        end else begin
            link_shift_r <= link_shift_nxt;
            link_tog_r <= link_tog_nxt;
        end
    end

    // System domain: pins and the edge toggle pass two flip-flops before use.
    dac_link_pkg::pin_sample_t cur;
    dac_link_pkg::pin_sample_t prev_r;
    dac_link_pkg::pin_sample_t prev_nxt;

    sync_2ff #(.WIDTH(3)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d({scl_clk, sda_i, link_tog_r}),
        .q(cur)
    );
    logic start_ev;
    logic stop_ev;
    logic fall_ev;
    logic rise_ev;
    always_comb begin
        prev_nxt = cur;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // Matches the synchroniser's reset output, so no false edge appears while it fills.
            prev_r <= '0;
        end else begin
            prev_r <= prev_nxt;
        end
    end

    // The toggle event trails the link edge by about two cycles, so the captured byte is
    // already stable when it is read here and stays so until the next bus clock rise.
    always_comb begin
        start_ev = cur.scl && prev_r.scl && prev_r.sda && !cur.sda;
        stop_ev = cur.scl && prev_r.scl && !prev_r.sda && cur.sda;
        fall_ev = prev_r.scl && !cur.scl;
        rise_ev = cur.tog ^ prev_r.tog;
    end

    dac_link_pkg::link_state_t state_r;
    dac_link_pkg::link_state_t state_nxt;
    logic [3:0] bit_cnt_r;
    logic [3:0] bit_cnt_nxt;
    logic byte_idx_r;
    logic byte_idx_nxt;
    logic drive_low_r;
    logic drive_low_nxt;
    logic addr_hit_r;
    logic addr_hit_nxt;
    logic read_dir_r;
    logic read_dir_nxt;
    logic rd_ack_r;
    logic rd_ack_nxt;
    dac_link_pkg::input_reg_t in_reg_r;
    dac_link_pkg::input_reg_t in_reg_nxt;
    dac_link_pkg::dac_reg_t dac_r;
    dac_link_pkg::dac_reg_t dac_nxt;
    logic [7:0] tx_byte;
    assign tx_byte = byte_idx_r ? in_reg_r[7:0] : in_reg_r[15:8];

    always_comb begin
        state_nxt = state_r;
        bit_cnt_nxt = bit_cnt_r;
        byte_idx_nxt = byte_idx_r;
        drive_low_nxt = drive_low_r;
        addr_hit_nxt = addr_hit_r;
        read_dir_nxt = read_dir_r;
        rd_ack_nxt = rd_ack_r;
        in_reg_nxt = in_reg_r;
        dac_nxt = dac_r;
        if (stop_ev) begin
            state_nxt = dac_link_pkg::ST_IDLE;
            drive_low_nxt = 1'b0;
        end else if (start_ev) begin
            state_nxt = dac_link_pkg::ST_ADDR;
            bit_cnt_nxt = 4'h0;
            byte_idx_nxt = 1'b0;
            drive_low_nxt = 1'b0;
        end else begin
            case (state_r)
                dac_link_pkg::ST_ADDR: begin
                    if (rise_ev && bit_cnt_r < dac_link_pkg::BITS_PER_BYTE) begin
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                        if (bit_cnt_r == dac_link_pkg::LAST_BIT_IDX) begin
                            // The low two address bits are deliberately not compared.
                            addr_hit_nxt = (link_shift_r[7:3] == dac_link_pkg::ADDR_UPPER);
                            read_dir_nxt = link_shift_r[0];
                        end
                    end
                    if (fall_ev && bit_cnt_r == dac_link_pkg::BITS_PER_BYTE) begin
                        if (addr_hit_r) begin
                            state_nxt = dac_link_pkg::ST_ADDR_ACK;
                            drive_low_nxt = 1'b1;
                        end else begin
                            state_nxt = dac_link_pkg::ST_IGNORE;
                        end
                    end
                end
                dac_link_pkg::ST_ADDR_ACK: begin
                    if (fall_ev) begin
                        bit_cnt_nxt = 4'h0;
                        if (read_dir_r) begin
                            state_nxt = dac_link_pkg::ST_RD_BYTE;
                            drive_low_nxt = !in_reg_r[15];
                        end else begin
                            state_nxt = dac_link_pkg::ST_WR_BYTE;
                            drive_low_nxt = 1'b0;
                        end
                    end
                end
                dac_link_pkg::ST_WR_BYTE: begin
                    if (rise_ev && bit_cnt_r < dac_link_pkg::BITS_PER_BYTE) begin
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                        if (bit_cnt_r == dac_link_pkg::LAST_BIT_IDX) begin
                            if (byte_idx_r) begin
                                in_reg_nxt[7:0] = link_shift_r;
                            end else begin
                                in_reg_nxt[15:8] = link_shift_r;
                            end
                        end
                    end
                    if (fall_ev && bit_cnt_r == dac_link_pkg::BITS_PER_BYTE) begin
                        state_nxt = dac_link_pkg::ST_WR_ACK;
                        drive_low_nxt = 1'b1;
                        if (byte_idx_r) begin
                            // Only a complete second byte reaches the converter register.
                            dac_nxt.power_down_control = in_reg_r.power_down_control;
                            dac_nxt.converter_code = in_reg_r.converter_code;
                        end
                    end
                end
                dac_link_pkg::ST_WR_ACK: begin
                    if (fall_ev) begin
                        drive_low_nxt = 1'b0;
                        bit_cnt_nxt = 4'h0;
                        if (byte_idx_r) begin
                            // Further bytes are left unacknowledged.
                            state_nxt = dac_link_pkg::ST_IGNORE;
                        end else begin
                            byte_idx_nxt = 1'b1;
                            state_nxt = dac_link_pkg::ST_WR_BYTE;
                        end
                    end
                end
                dac_link_pkg::ST_RD_BYTE: begin
                    if (rise_ev && bit_cnt_r < dac_link_pkg::BITS_PER_BYTE) begin
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end
                    if (fall_ev) begin
                        if (bit_cnt_r == dac_link_pkg::BITS_PER_BYTE) begin
                            state_nxt = dac_link_pkg::ST_RD_ACK;
                            drive_low_nxt = 1'b0;
                        end else begin
                            drive_low_nxt = !tx_byte[~bit_cnt_r[2:0]];
                        end
                    end
                end
                dac_link_pkg::ST_RD_ACK: begin
                    if (rise_ev) begin
                        rd_ack_nxt = !link_shift_r[0];
                        if (byte_idx_r) begin
                            in_reg_nxt = dac_link_pkg::INPUT_REG_RESET;
                        end
                    end
                    if (fall_ev) begin
                        bit_cnt_nxt = 4'h0;
                        if (rd_ack_r && !byte_idx_r) begin
                            byte_idx_nxt = 1'b1;
                            state_nxt = dac_link_pkg::ST_RD_BYTE;
                            drive_low_nxt = !in_reg_r[7];
                        end else begin
                            state_nxt = dac_link_pkg::ST_IGNORE;
                        end
                    end
                end
                default: begin
                    drive_low_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= dac_link_pkg::ST_IDLE;
            bit_cnt_r <= 4'h0;
            byte_idx_r <= 1'b0;
            drive_low_r <= 1'b0;
            addr_hit_r <= 1'b0;
            read_dir_r <= 1'b0;
            rd_ack_r <= 1'b0;
            in_reg_r <= dac_link_pkg::INPUT_REG_RESET;
            dac_r <= dac_link_pkg::DAC_REG_RESET;
        end else begin
            state_r <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            byte_idx_r <= byte_idx_nxt;
            drive_low_r <= drive_low_nxt;
            addr_hit_r <= addr_hit_nxt;
            read_dir_r <= read_dir_nxt;
            rd_ack_r <= rd_ack_nxt;
            in_reg_r <= in_reg_nxt;
            dac_r <= dac_nxt;
        end
    end

    // Open drain: the pin is only ever pulled low, never driven high.
    assign sda_o = 1'b0;
    assign sda_oe = drive_low_r;
    assign converter_code = dac_r.converter_code;
    // The pin term bypasses every flip-flop so power-down acts even with no clock running.
    assign power_down = power_down_pin | dac_r.power_down_control;
    assign link_busy = (state_r != dac_link_pkg::ST_IDLE);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_addr_done;
        state_r == dac_link_pkg::ST_ADDR && !start_ev && !stop_ev && fall_ev
            && bit_cnt_r == dac_link_pkg::BITS_PER_BYTE;
    endsequence

    sequence s_wr_done;
        state_r == dac_link_pkg::ST_WR_BYTE && !start_ev && !stop_ev && fall_ev
            && bit_cnt_r == dac_link_pkg::BITS_PER_BYTE;
    endsequence

    property p_oe_states;
        sda_oe |-> (state_r == dac_link_pkg::ST_ADDR_ACK || state_r == dac_link_pkg::ST_WR_ACK
            || state_r == dac_link_pkg::ST_RD_BYTE);
    endproperty
    a_oe_states: assert property (p_oe_states) else $error("data line pulled outside a driving state");

    property p_start;
        start_ev && !stop_ev |=> state_r == dac_link_pkg::ST_ADDR && bit_cnt_r == 4'h0 && !sda_oe;
    endproperty
    a_start: assert property (p_start) else $error("start did not restart address capture");

    property p_ack_match;
        s_addr_done and (addr_hit_r == 1'b1) |=> sda_oe && state_r == dac_link_pkg::ST_ADDR_ACK;
    endproperty
    a_ack_match: assert property (p_ack_match) else $error("matching address not acknowledged");

    property p_ignore_other;
        s_addr_done and (addr_hit_r == 1'b0) |=> !sda_oe && state_r == dac_link_pkg::ST_IGNORE;
    endproperty
    a_ignore_other: assert property (p_ignore_other) else $error("foreign address was answered");

    property p_change_low;
        $changed(sda_oe) && !$past(start_ev) && !$past(stop_ev) |-> !cur.scl;
    endproperty
    a_change_low: assert property (p_change_low) else $error("data line changed while clock high");

    property p_wr_ack;
        s_wr_done |=> sda_oe ##0 (sda_oe throughout (!fall_ev && !start_ev && !stop_ev) [*2]);
    endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("received byte not acknowledged");

    property p_copy_cause;
        $changed(dac_r) |-> $past(state_r) == dac_link_pkg::ST_WR_BYTE && $past(byte_idx_r)
            && dac_r.converter_code == $past(in_reg_r.converter_code);
    endproperty
    a_copy_cause: assert property (p_copy_cause) else $error("converter register changed without full write");

    property p_high_byte;
        state_r == dac_link_pkg::ST_WR_BYTE && rise_ev && !start_ev && !stop_ev && !byte_idx_r
            && bit_cnt_r == dac_link_pkg::LAST_BIT_IDX |=> in_reg_r[15:8] == $past(link_shift_r);
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("high byte not stored first");

    property p_read_clear;
        state_r == dac_link_pkg::ST_RD_ACK && rise_ev && byte_idx_r && !start_ev && !stop_ev
            |=> in_reg_r == dac_link_pkg::INPUT_REG_RESET;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("input register not cleared after read");

    property p_pd_pin;
        power_down_pin |-> power_down;
    endproperty
    a_pd_pin: assert property (p_pd_pin) else $error("power-down pin not honoured");

endmodule
`default_nettype wire

// [dv/i2c_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
    output logic scl,
    output logic sda_pull,
    input wire logic sda_line
);
    // The bus clock only moves inside frames and rests high between them.
    localparam int STEP_NS = 32;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic tick(input int n);
        #(STEP_NS * n);
    endtask

    // The data line is only pulled low; a released data line floats to the pull-up level.
    task automatic start();
        if (!scl) begin
            tick(8);
            sda_pull = 1'b0;
            tick(8);
            scl = 1'b1;
            tick(16);
        end
        sda_pull = 1'b1;
        tick(16);
        scl = 1'b0;
    endtask

    // Data moves only in the middle of the low phase.
    task automatic clock_bit(input logic val, output logic seen);
        tick(8);
        sda_pull = !val;
        tick(8);
        scl = 1'b1;
        tick(8);
        seen = sda_line;
        tick(8);
        scl = 1'b0;
    endtask

    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], s);
        end
        clock_bit(1'b1, s);
        ack = !s;
    endtask

    task automatic read_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, b[i]);
        end
        clock_bit(!ack, s);
    endtask

    task automatic stop();
        tick(8);
        sda_pull = 1'b1;
        tick(8);
        scl = 1'b1;
        tick(16);
        sda_pull = 1'b0;
        tick(16);
    endtask
endmodule
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic resetn;
    logic power_down_pin;
    logic sda_o;
    logic sda_oe;
    logic power_down;
    logic link_busy;
    logic scl;
    logic sda_pull;
    logic sda_line;
    logic [9:0] converter_code;
    logic [15:0] cur;
    int error_cnt;
    int tests_run;

    // Wired-and with a pull-up: low whenever either party pulls.
    assign sda_line = !(sda_oe && !sda_o) && !sda_pull;

    i2c_ctrl_model ctrl (.scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));

    i2c_dac_code_interface dut (
        .clk(clk),
        .resetn(resetn),
        .scl_clk(scl),
        .sda_i(sda_line),
        .sda_o(sda_o),
        .sda_oe(sda_oe),
        .power_down_pin(power_down_pin),
        .converter_code(converter_code),
        .power_down(power_down),
        .link_busy(link_busy)
    );

    always #25 clk = ~clk;

    function automatic logic [15:0] exp_out(input logic [15:0] w, input logic pin);
        exp_out = {5'h00, w[dac_link_pkg::PD_BIT] | pin, w[dac_link_pkg::CODE_MSB:dac_link_pkg::CODE_LSB]};
    endfunction

    task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_word(what, {15'h0000, exp}, {15'h0000, got});
    endtask

    task automatic outs();
        chk_word("outputs", exp_out(cur, power_down_pin), {5'h00, power_down, converter_code});
    endtask

    task automatic wr_word(input logic [7:0] addr, input logic [15:0] w, input logic hit);
        logic a;
        ctrl.start();
        ctrl.write_byte(addr, a);
        chk_bit("addr_ack", hit, a);
        chk_bit("busy", 1'b1, link_busy);
        ctrl.write_byte(w[15:8], a);
        chk_bit("hi_ack", hit, a);
        ctrl.write_byte(w[7:0], a);
        chk_bit("lo_ack", hit, a);
        if (hit) begin
            cur = w;
        end
        ctrl.stop();
        repeat (4) @(negedge clk);
        chk_bit("idle", 1'b0, link_busy);
        outs();
    endtask

    task automatic rd_word(input logic [7:0] addr, input logic [15:0] exp);
        logic a;
        logic [7:0] hi;
        logic [7:0] lo;
        ctrl.start();
        ctrl.write_byte(addr, a);
        chk_bit("rd_ack", 1'b1, a);
        ctrl.read_byte(1'b1, hi);
        ctrl.read_byte(1'b0, lo);
        ctrl.stop();
        chk_word("read", exp, {hi, lo});
        outs();
    endtask

    task automatic final_report();
        $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // The full sequence needs under a millisecond of bus traffic, so two leave ample margin.
    initial begin
        #2000000;
        error_cnt++;
        final_report();
    end

    initial begin
        logic [15:0] w;
        logic [7:0] a;
        logic k;
        resetn = 1'b0;
        power_down_pin = 1'b0;
        error_cnt = 0;
        tests_run = 0;
        cur = 16'h0000;
        void'($urandom(46790));
        repeat (5) @(negedge clk);
        outs();
        chk_bit("rst_oe", 1'b0, sda_oe);
        chk_bit("sda_o", 1'b0, sda_o);
        resetn = 1'b1;
        repeat (6) @(negedge clk);
        outs();
        $display("test reset done");

        // Corner words first: full code, then soft power-down with every spare bit set.
        for (int i = 0; i < 6; i++) begin
            w = (i == 0) ? 16'h3ff0 : (i == 1) ? 16'hc00f : 16'($urandom);
            wr_word(8'h18 | 8'(2 * (i % 4)), w, 1'b1);
            rd_word(8'h19 | 8'(2 * (i % 4)), w);
            rd_word(8'h19, 16'h0000);
        end
        $display("test write_read done");

        for (int i = 0; i < 3; i++) begin
            a = 8'($urandom);
            if (a[7:3] == 5'h03) begin
                a[7] = 1'b1;
            end
            wr_word(a, 16'($urandom), 1'b0);
        end
        $display("test foreign_address done");

        ctrl.start();
        ctrl.write_byte(8'h1c, k);
        ctrl.write_byte(8'hff, k);
        ctrl.stop();
        outs();
        ctrl.start();
        ctrl.write_byte(8'h1e, k);
        ctrl.write_byte(8'h7f, k);
        outs();
        wr_word(8'h18, 16'($urandom), 1'b1);
        $display("test partial_write done");

        w = 16'($urandom) & 16'h7fff;
        ctrl.start();
        ctrl.write_byte(8'h1a, k);
        ctrl.write_byte(w[15:8], k);
        ctrl.write_byte(w[7:0], k);
        ctrl.write_byte(8'ha5, k);
        chk_bit("third_ack", 1'b0, k);
        ctrl.stop();
        cur = w;
        repeat (4) @(negedge clk);
        outs();
        $display("test third_byte done");

        // A read refused after its first byte must not clear the input register.
        ctrl.start();
        ctrl.write_byte(8'h1b, k);
        ctrl.read_byte(1'b0, a);
        ctrl.stop();
        chk_word("nack_read", {8'h00, w[15:8]}, {8'h00, a});
        rd_word(8'h1d, w);
        $display("test early_nack done");

        @(negedge clk);
        power_down_pin = 1'b1;
        #1;
        chk_bit("pd_pin", 1'b1, power_down);
        @(negedge clk);
        power_down_pin = 1'b0;
        #1;
        chk_bit("pd_pin", 1'b0, power_down);
        $display("test power_down_pin done");
        final_report();
    end
endmodule
`default_nettype wire
